// ### hw/mmd_space_pkg.sv
// constants and types shared by the management register space
//
// How it works
// - reserved device address reads zero, ignores writes
// - decode 5-bit device address to five managed devices
// - registers are 16 bits, 16-bit register address
// - every access moves one whole 16-bit word
// - latch-low bit drops, interrupts, read restores one
// - latch-high bit sets, interrupts, read clears zero
// - any edge sets transition bit until read
// - read-only fields show live value, ignore writes
// - fixed read-only fields never change, ignore writes
// - self-clear bit starts action, clears when done
// - single counter saturates, read-only, clears on read
// - low word read snapshots high word, clears pair
// - vendor registers start at offset c000 upward
// - vendor region split into 1k-word blocks
// - standard and vendor alarms use separate masks
// - two trees feed global summary driving pin
// - standard source found within two reads
// - vendor source found within three reads
// - every source masked, masked never reaches pin
package mmd_space_pkg;

   // ----------------------------------------------------------------
   // managed device addresses
   // ----------------------------------------------------------------
   localparam int NUM_MMD = 5;
   localparam logic [4:0] DEV_PMA = 5'h01;
   localparam logic [4:0] DEV_PCS = 5'h03;
   localparam logic [4:0] DEV_AN = 5'h07;
   localparam logic [4:0] DEV_GBE = 5'h1d;
   localparam logic [4:0] DEV_GLOBAL = 5'h1e;
   localparam logic [2:0] IDX_GLOBAL = 3'h4;
   localparam logic [2:0] IDX_NONE = 3'h7;

   // ----------------------------------------------------------------
   // register addresses inside each device
   // ----------------------------------------------------------------
   localparam logic [15:0] REG_CTRL = 16'h0000;
   localparam logic [15:0] REG_STATUS = 16'h0001;
   localparam logic [15:0] REG_IDENT = 16'h0002;
   localparam logic [15:0] VENDOR_BASE = 16'hc000;
   localparam logic [15:0] REG_PROV = 16'hc400;
   localparam logic [15:0] REG_STATE = 16'hc800;
   localparam logic [15:0] REG_CNT_SINGLE = 16'hc820;
   localparam logic [15:0] REG_CNT_LOW = 16'hc821;
   localparam logic [15:0] REG_CNT_HIGH = 16'hc822;
   localparam logic [15:0] REG_VALARM = 16'hcc00;
   localparam logic [15:0] REG_SMASK = 16'hd000;
   localparam logic [15:0] REG_VMASK = 16'hd400;
   localparam logic [15:0] REG_FLAGS = 16'hfc00;

   // ----------------------------------------------------------------
   // field positions, reset values and action length
   // ----------------------------------------------------------------
   localparam int SC_BIT = 15;
   localparam int LL_BIT = 2;
   localparam int LH_BIT = 7;
   localparam int LT_BIT = 0;
   localparam int FLAG_STD_BIT = 0;
   localparam int FLAG_VEND_BIT = 1;
   localparam logic [15:0] PROV_RESET = 16'h0000;
   localparam logic [7:0] SC_ACTION_CYCLES = 8'h10;

   // ----------------------------------------------------------------
   // bus-side register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] AHB_ADDR_FRAME = 8'h00;
   localparam logic [7:0] AHB_DATA_FRAME = 8'h04;

   // bus slave states
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACCESS = 1'b1
   } bus_state_t;

endpackage : mmd_space_pkg

// ### hw/mmd_space.sv
// management register space of five managed devices behind an ahb-lite slave
module mmd_space #(
   parameter logic [15:0] IDENT_CODE = 16'h5a5a // arbitrary identification value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // monitored conditions per device, same clock
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] link_cond,
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] fault_cond,
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] event_cond,
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] count_inc,
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] pair_inc,
   // actions and interrupt
   output logic [mmd_space_pkg::NUM_MMD-1:0] mmd_soft_reset,
   output logic int_n
);
   import mmd_space_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      bus_state_t bus; // slave phase
      logic ready; // drives hreadyout
      logic wr; // held write flag
      logic [7:0] off; // held byte offset
      logic [31:0] hrdata; // read data register
      logic [4:0] dev; // selected device address
      logic [15:0] regaddr; // selected register address
      logic int_n; // interrupt pin, active low
      logic [NUM_MMD-1:0] sc; // self-clear action bits
      logic [NUM_MMD-1:0][7:0] sc_cnt; // action progress
      logic [NUM_MMD-1:0] ll; // latch-low status bits
      logic [NUM_MMD-1:0] lh; // latch-high status bits
      logic [NUM_MMD-1:0] lt; // transition alarm bits
      logic [NUM_MMD-1:0] cond_prev; // last event condition
      logic [NUM_MMD-1:0][15:0] prov; // provisioning words
      logic [NUM_MMD-1:0][15:0] smask; // standard masks
      logic [NUM_MMD-1:0][15:0] vmask; // vendor masks
      logic [NUM_MMD-1:0][15:0] cnt1; // single-word counters
      logic [NUM_MMD-1:0][31:0] cnt2; // two-word counters
      logic [NUM_MMD-1:0][15:0] shadow; // high-word snapshots
   } state_t;

   state_t s_reg; // registered state
   state_t s_next; // next state

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // map a device address to an array index, reserved gives none
   function automatic logic [2:0] mmd_index(input logic [4:0] dev);
      logic [2:0] idx;
      idx = IDX_NONE;
      case (dev)
         DEV_PMA: idx = 3'h0;
         DEV_PCS: idx = 3'h1;
         DEV_AN: idx = 3'h2;
         DEV_GBE: idx = 3'h3;
         DEV_GLOBAL: idx = IDX_GLOBAL;
         default: idx = IDX_NONE;
      endcase
      return idx;
   endfunction : mmd_index

   // standard status word: latch-high bit and latch-low bit
   function automatic logic [15:0] status_word(input logic lh, input logic ll);
      logic [15:0] w;
      w = 16'h0000;
      w[LH_BIT] = lh;
      w[LL_BIT] = ll;
      return w;
   endfunction : status_word

   // ----------------------------------------------------------------
   // combinational decode
   // ----------------------------------------------------------------
   logic [2:0] idx; // selected device index
   logic acc; // data frame access to a real device
   logic [NUM_MMD-1:0] rd_sel; // one-hot read target
   logic [NUM_MMD-1:0] wr_sel; // one-hot write target
   logic [NUM_MMD-1:0] std_pend; // unmasked standard flags
   logic [NUM_MMD-1:0] vend_pend; // unmasked vendor flags
   logic [15:0] rd; // word read from the space
   logic [15:0] wdat; // word written to the space

   // selection and pending summaries from current state
   always_comb begin
      idx = mmd_index(s_reg.dev);
      acc = (s_reg.bus == BUS_ACCESS) && (s_reg.off == AHB_DATA_FRAME) && (idx != IDX_NONE);
      wdat = hwdata[15:0];
      rd_sel = '0;
      wr_sel = '0;
      std_pend = '0;
      vend_pend = '0;
      for (int m = 0; m < NUM_MMD; m++) begin
         if (acc && (idx == 3'(m))) begin
            rd_sel[m] = !s_reg.wr;
            wr_sel[m] = s_reg.wr;
         end
         // leaf flags gated by their own masks
         std_pend[m] = |(status_word(s_reg.lh[m], !s_reg.ll[m]) & s_reg.smask[m]);
         vend_pend[m] = s_reg.lt[m] & s_reg.vmask[m][LT_BIT];
      end
   end

   // read multiplexer over one device's registers
   always_comb begin
      rd = 16'h0000;
      if (acc) begin
         case (s_reg.regaddr)
            REG_CTRL: begin
               rd = 16'h0000;
               rd[SC_BIT] = s_reg.sc[idx];
            end
            REG_STATUS: rd = status_word(s_reg.lh[idx], s_reg.ll[idx]);
            REG_IDENT: rd = IDENT_CODE;
            REG_PROV: rd = s_reg.prov[idx];
            // live state of the monitored conditions
            REG_STATE: rd = {13'h0000, event_cond[idx], fault_cond[idx], link_cond[idx]};
            REG_CNT_SINGLE: rd = s_reg.cnt1[idx];
            REG_CNT_LOW: rd = s_reg.cnt2[idx][15:0];
            REG_CNT_HIGH: rd = s_reg.shadow[idx];
            REG_VALARM: begin
               rd = 16'h0000;
               rd[LT_BIT] = s_reg.lt[idx];
            end
            REG_SMASK: rd = s_reg.smask[idx];
            REG_VMASK: rd = s_reg.vmask[idx];
            REG_FLAGS: begin
               if (idx == IDX_GLOBAL) begin
                  // top summary: one bit per device in each tree
                  rd = {3'h0, vend_pend, 3'h0, std_pend};
               end else begin
                  // per-device standard and vendor flags, second step of vendor tree
                  rd = 16'h0000;
                  rd[FLAG_STD_BIT] = std_pend[idx];
                  rd[FLAG_VEND_BIT] = vend_pend[idx];
               end
            end
            default: rd = 16'h0000; // unmapped register reads zero
         endcase
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;

      // per-device status, counters and actions
      for (int m = 0; m < NUM_MMD; m++) begin
         s_next.cond_prev[m] = event_cond[m];

         // latch-low: a low condition wins over the read restore
         if (!link_cond[m]) begin
            s_next.ll[m] = 1'b0;
         end else if (rd_sel[m] && (s_reg.regaddr == REG_STATUS)) begin
            s_next.ll[m] = 1'b1;
         end

         // latch-high: set wins over clear-on-read
         s_next.lh[m] = fault_cond[m] | (s_reg.lh[m] & !(rd_sel[m] && (s_reg.regaddr == REG_STATUS)));

         // transition: either edge sets, read clears
         s_next.lt[m] = (event_cond[m] ^ s_reg.cond_prev[m])
            | (s_reg.lt[m] & !(rd_sel[m] && (s_reg.regaddr == REG_VALARM)));

         // single-word counter, saturating, clear on read
         if (rd_sel[m] && (s_reg.regaddr == REG_CNT_SINGLE)) begin
            s_next.cnt1[m] = {15'h0000, count_inc[m]};
         end else if (count_inc[m] && (s_reg.cnt1[m] != 16'hffff)) begin
            s_next.cnt1[m] = s_reg.cnt1[m] + 16'h0001;
         end

         // two-word counter: low read snapshots high and clears pair
         if (rd_sel[m] && (s_reg.regaddr == REG_CNT_LOW)) begin
            s_next.shadow[m] = s_reg.cnt2[m][31:16];
            s_next.cnt2[m] = {31'h00000000, pair_inc[m]};
         end else if (pair_inc[m] && (s_reg.cnt2[m] != 32'hffffffff)) begin
            s_next.cnt2[m] = s_reg.cnt2[m] + 32'h00000001;
         end

         // self-clear action runs its count then drops
         if (s_reg.sc[m]) begin
            if (s_reg.sc_cnt[m] == SC_ACTION_CYCLES - 8'h01) begin
               s_next.sc[m] = 1'b0;
               s_next.sc_cnt[m] = 8'h00;
            end else begin
               s_next.sc_cnt[m] = s_reg.sc_cnt[m] + 8'h01;
            end
         end

         // writes: only writable words take data, others ignore it
         if (wr_sel[m]) begin
            case (s_reg.regaddr)
               REG_CTRL: begin
                  if (wdat[SC_BIT] && !s_reg.sc[m]) begin
                     s_next.sc[m] = 1'b1;
                     s_next.sc_cnt[m] = 8'h00;
                  end
               end
               REG_PROV: s_next.prov[m] = wdat;
               REG_SMASK: s_next.smask[m] = wdat;
               REG_VMASK: s_next.vmask[m] = wdat;
               default: s_next.prov[m] = s_reg.prov[m];
            endcase
         end
      end

      // interrupt pin low while any unmasked flag stands
      s_next.int_n = !((|std_pend) | (|vend_pend));

      // bus slave: one wait state, then the answer
      case (s_reg.bus)
         BUS_IDLE: begin
            s_next.ready = 1'b1;
            if (hsel && htrans[1] && hready) begin
               s_next.bus = BUS_ACCESS;
               s_next.ready = 1'b0;
               s_next.wr = hwrite;
               s_next.off = haddr[7:0];
            end
         end
         BUS_ACCESS: begin
            s_next.bus = BUS_IDLE;
            s_next.ready = 1'b1;
            s_next.hrdata = 32'h00000000;
            if (s_reg.off == AHB_ADDR_FRAME) begin
               if (s_reg.wr) begin
                  // address frame selects device and register
                  s_next.dev = hwdata[20:16];
                  s_next.regaddr = hwdata[15:0];
               end else begin
                  s_next.hrdata = {11'h000, s_reg.dev, s_reg.regaddr};
               end
            end else if ((s_reg.off == AHB_DATA_FRAME) && !s_reg.wr) begin
               s_next.hrdata = {16'h0000, rd};
            end
         end
         default: begin
            s_next.bus = BUS_IDLE;
            s_next.ready = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.ready <= 1'b1;
         s_reg.int_n <= 1'b1;
         s_reg.ll <= '1;
         s_reg.prov <= {NUM_MMD{PROV_RESET}};
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops except hresp, tied low
   // ----------------------------------------------------------------
   assign hrdata = s_reg.hrdata;
   assign hreadyout = s_reg.ready;
   assign hresp = 1'b0;
   assign mmd_soft_reset = s_reg.sc;
   assign int_n = s_reg.int_n;

endmodule : mmd_space

// ### verif/mmd_space_chk.sv
// concurrent checks on the ports of the management register space
module mmd_space_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // actions and interrupt
   input wire logic [mmd_space_pkg::NUM_MMD-1:0] mmd_soft_reset,
   input wire logic int_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_space_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic take; // address phase accepted
   logic [7:0] sc_cnt_reg; // cycles of the current action pulse
   logic [7:0] off_reg; // offset of the last accepted transfer
   assign take = hsel && htrans[1] && hready;
   // remember which frame the current data phase belongs to
   always_ff @(posedge clk) begin
      if (rst) begin
         off_reg <= 8'h00;
      end else if (take) begin
         off_reg <= haddr[7:0];
      end
   end
   // count how long any action bit has been high
   always_ff @(posedge clk) begin
      if (rst || ~|mmd_soft_reset) begin
         sc_cnt_reg <= 8'h00;
      end else begin
         sc_cnt_reg <= sc_cnt_reg + 8'h01;
      end
   end
   a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   a_one_wait: assert property (take |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
   a_wait_cause: assert property (!hreadyout |-> $past(take)) else $error("stray wait state");
   // address frame reads echo the device address, data frames hold 16 bits only
   a_upper_zero: assert property ($past(!hreadyout) |-> (hrdata[31:21] == 11'h0)
      && ((off_reg != AHB_DATA_FRAME) || (hrdata[20:16] == 5'h0))) else $error("upper read bits set");
   a_data_stands: assert property (!$past(rst) && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   a_sc_cause: assert property ($rose(|mmd_soft_reset) |-> $past(!hreadyout) && $past(hwdata[SC_BIT]))
      else $error("action without write");
   a_sc_length: assert property ($fell(|mmd_soft_reset) && !$past(rst) |-> sc_cnt_reg == 8'h10)
      else $error("action length wrong");
   a_sc_bound: assert property (sc_cnt_reg <= 8'h10) else $error("action never ends");
   a_int_release: assert property ($rose(int_n) && !$past(rst) |-> !$past(hreadyout, 2))
      else $error("interrupt released without access");
   a_int_reset: assert property ($fell(rst) |-> int_n) else $error("interrupt after reset");
   // main scenarios reached
   cover property (take);
   cover property ($fell(int_n));
   cover property ($fell(|mmd_soft_reset));
endmodule : mmd_space_chk

bind mmd_space mmd_space_chk chk (
   .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .mmd_soft_reset(mmd_soft_reset), .int_n(int_n)
);

// ### verif/mmd_host_model.sv
// management host model: frames carried as whole-word bus transfers
module mmd_host_model (
   // clock
   input wire logic clk,
   // bus master side
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_space_pkg::*;
   // idle bus at time zero, word size fixed
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // one transfer, each phase held until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      haddr <= ~{24'h0, a};
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
      hwdata <= ~d; // stale data scrambled
   endtask : bus
   // address frame then write frame
   task automatic wr(input logic [4:0] dev, input logic [15:0] ra, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, AHB_ADDR_FRAME, {11'h0, dev, ra}, q);
      bus(1'b1, AHB_DATA_FRAME, d, q);
   endtask : wr
   // address frame then read frame
   task automatic rd(input logic [4:0] dev, input logic [15:0] ra, output logic [31:0] q);
      bus(1'b1, AHB_ADDR_FRAME, {11'h0, dev, ra}, q);
      bus(1'b0, AHB_DATA_FRAME, 32'h0, q);
   endtask : rd
   // low word first, then its shadowed high word
   task automatic rd_pair(input logic [4:0] dev, output logic [31:0] lo, output logic [31:0] hi);
      rd(dev, REG_CNT_LOW, lo);
      rd(dev, REG_CNT_HIGH, hi);
   endtask : rd_pair
endmodule : mmd_host_model

// ### verif/mmd_space_test.sv
// self-checking bench for the management register space
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module mmd_space_test;
   timeunit 1ns;
   timeprecision 1ps;
   import mmd_space_pkg::*;
   localparam logic [15:0] ID_VAL = 16'h3c3c; // arbitrary identification value
   logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, int_n;
   logic [31:0] haddr, hwdata, hrdata, q, q2;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] link_cond, fault_cond, event_cond, count_inc, pair_inc, mmd_soft_reset, dev;
   logic [4:0] dev_tab [NUM_MMD] = '{DEV_PMA, DEV_PCS, DEV_AN, DEV_GBE, DEV_GLOBAL};
   integer err_count = 0, total_checks = 0, seed = 32'h3166, cycles = 0, i, k, n;
   assign hready = hreadyout; // single slave
   mmd_space #(.IDENT_CODE(ID_VAL)) dut (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link_cond(link_cond), .fault_cond(fault_cond), .event_cond(event_cond), .count_inc(count_inc),
      .pair_inc(pair_inc), .mmd_soft_reset(mmd_soft_reset), .int_n(int_n)
   );
   mmd_host_model host (
      .clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata)
   );
   // expected status word from the two latch bits
   function automatic logic [31:0] exp_status(input logic ll, input logic lh);
      return {24'h0, lh, 4'h0, ll, 2'h0};
   endfunction : exp_status
   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      link_cond = 5'h1f;
      fault_cond = 5'h0;
      event_cond = 5'h0;
      count_inc = 5'h0;
      pair_inc = 5'h0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // per device: provisioning, fixed, live and unused words
      for (i = 0; i < NUM_MMD; i++) begin
         n = $random(seed);
         host.wr(dev_tab[i], REG_PROV, n);
         host.rd(dev_tab[i], REG_PROV, q);
         `CHECK(q, {16'h0, n[15:0]})
         host.wr(dev_tab[i], REG_IDENT, ~n);
         host.rd(dev_tab[i], REG_IDENT, q);
         `CHECK(q, {16'h0, ID_VAL})
         host.rd(dev_tab[i], REG_STATUS, q);
         `CHECK(q, exp_status(1'b1, 1'b0))
         host.wr(dev_tab[i], REG_STATE, 32'hffff);
         host.rd(dev_tab[i], REG_STATE, q);
         `CHECK(q, 32'h1)
         host.rd(dev_tab[i], 16'hdc00, q);
         `CHECK(q, 32'h0)
      end
      $display("done: register map");
      // reserved device addresses
      for (i = 0; i < 8; i++) begin
         dev = (i == 0) ? 5'h00 : 5'($random(seed));
         if (dev inside {DEV_PMA, DEV_PCS, DEV_AN, DEV_GBE, DEV_GLOBAL}) dev = 5'h1f;
         host.wr(dev, REG_PROV, 32'hbeef);
         host.rd(dev, REG_PROV, q);
         `CHECK(q, 32'h0)
      end
      host.bus(1'b0, AHB_ADDR_FRAME, 32'h0, q);
      `CHECK(q, {11'h0, dev, REG_PROV})
      host.rd(DEV_GLOBAL, REG_PROV, q);
      `CHECK(q, {16'h0, n[15:0]})
      $display("done: reserved devices");
      // latch bits with all masks clear
      k = {$random(seed)} % 4;
      dev = dev_tab[k];
      link_cond[k] <= 1'b0;
      fault_cond[k] <= 1'b1;
      event_cond[k] <= 1'b1;
      @(posedge clk);
      link_cond[k] <= 1'b1;
      fault_cond[k] <= 1'b0;
      repeat (3) @(posedge clk);
      `CHECK(int_n, 1'b1)
      host.rd(dev, REG_STATUS, q);
      `CHECK(q, exp_status(1'b0, 1'b1))
      host.wr(dev, REG_STATUS, 32'h0);
      host.rd(dev, REG_STATUS, q);
      `CHECK(q, exp_status(1'b1, 1'b0))
      host.rd(dev, REG_VALARM, q);
      `CHECK(q, 32'h1)
      host.rd(dev, REG_VALARM, q);
      `CHECK(q, 32'h0)
      $display("done: latch bits");
      // standard then vendor interrupt through both trees
      host.wr(dev, REG_SMASK, 32'h80);
      fault_cond[k] <= 1'b1;
      @(posedge clk);
      fault_cond[k] <= 1'b0;
      repeat (3) @(posedge clk);
      `CHECK(int_n, 1'b0)
      host.rd(DEV_GLOBAL, REG_FLAGS, q);
      `CHECK(q, 32'h1 << k)
      host.rd(dev, REG_FLAGS, q);
      `CHECK(q, 32'h1)
      host.rd(dev, REG_STATUS, q);
      repeat (2) @(posedge clk);
      `CHECK(int_n, 1'b1)
      // latch-low source through the standard mask
      host.wr(dev, REG_SMASK, 32'h4);
      link_cond[k] <= 1'b0;
      @(posedge clk);
      link_cond[k] <= 1'b1;
      repeat (3) @(posedge clk);
      `CHECK(int_n, 1'b0)
      host.rd(dev, REG_STATUS, q);
      `CHECK(q, exp_status(1'b0, 1'b0))
      repeat (2) @(posedge clk);
      `CHECK(int_n, 1'b1)
      host.wr(dev, REG_VMASK, 32'h1);
      event_cond[k] <= 1'b0;
      repeat (4) @(posedge clk);
      `CHECK(int_n, 1'b0)
      host.rd(DEV_GLOBAL, REG_FLAGS, q);
      `CHECK(q, 32'h100 << k)
      host.rd(dev, REG_FLAGS, q);
      `CHECK(q, 32'h2)
      host.rd(dev, REG_VALARM, q);
      `CHECK(q, 32'h1)
      $display("done: interrupts");
      // self-clearing action
      k = {$random(seed)} % NUM_MMD;
      host.wr(dev_tab[k], REG_CTRL, 32'h8000);
      #1;
      `CHECK(mmd_soft_reset, 5'h1 << k)
      @(posedge clk);
      host.rd(dev_tab[k], REG_CTRL, q);
      `CHECK(q[15], 1'b1)
      repeat (20) @(posedge clk);
      host.rd(dev_tab[k], REG_CTRL, q);
      `CHECK(q, 32'h0)
      $display("done: self clear");
      // counters: short count, then saturation and pair carry
      dev = dev_tab[k];
      n = 3 + {$random(seed)} % 10;
      count_inc[k] <= 1'b1;
      repeat (n) @(posedge clk);
      count_inc[k] <= 1'b0;
      host.rd(dev, REG_CNT_SINGLE, q);
      `CHECK(q, {16'h0, n[15:0]})
      host.rd(dev, REG_CNT_SINGLE, q);
      `CHECK(q, 32'h0)
      count_inc[k] <= 1'b1;
      pair_inc[k] <= 1'b1;
      repeat (65540) @(posedge clk);
      count_inc[k] <= 1'b0;
      pair_inc[k] <= 1'b0;
      host.rd(dev, REG_CNT_SINGLE, q);
      `CHECK(q, 32'hffff)
      host.rd_pair(dev, q, q2);
      `CHECK({q2[15:0], q[15:0]}, 32'h10004)
      host.rd_pair(dev, q, q2);
      `CHECK({q2[15:0], q[15:0]}, 32'h0)
      $display("done: counters");
      end_sim();
   end
endmodule : mmd_space_test
